// [lsb_defs.svh]
`ifndef LSB_DEFS_SVH
`define LSB_DEFS_SVH

// Register indices; byte address is four times the index
`define LSB_IDX_CUR_HIGH 6'h07
`define LSB_IDX_CUR_LOW 6'h08
`define LSB_IDX_FE_CTRL 6'h0A
`define LSB_IDX_DEAD_TIME 6'h0B
`define LSB_IDX_FAULT 6'h0C
`define LSB_IDX_SEQ_STAT 6'h10

// Reset values
`define LSB_RST_CUR_HIGH 2'h0
`define LSB_RST_CUR_LOW 8'h00
`define LSB_RST_TRIM 1'b0
`define LSB_RST_GAIN 2'h0
`define LSB_RST_SEL 3'h0
`define LSB_RST_DEAD_TIME 8'h00
`define LSB_RST_FAULT 8'h00

// Field positions
`define LSB_FE_ON_BIT 6
`define LSB_TRIM_BIT 5
`define LSB_GAIN_HI 4
`define LSB_GAIN_LO 3
`define LSB_SEL_HI 2
`define LSB_SEL_LO 0
`define LSB_CUR_HIGH_HI 1
`define LSB_STAT_BUSY_BIT 0
`define LSB_STAT_DEAD_BIT 1

// Timing
`define LSB_CLK_PERIOD_NS 25
`define LSB_OPEN_MIN_NS 333
`define LSB_OPEN_MAX_NS 444
`define LSB_OPEN_CYC ((`LSB_OPEN_MIN_NS + `LSB_CLK_PERIOD_NS - 1) / `LSB_CLK_PERIOD_NS)
`define LSB_OPEN_MAX_CYC (`LSB_OPEN_MAX_NS / `LSB_CLK_PERIOD_NS)
`define LSB_DEAD_BASE_NS 222
`define LSB_DEAD_STEP_NS 111

`endif

// [lsb_pkg.sv]
package lsb_pkg;

    typedef enum logic [1:0] {
        LSB_GAIN_OFF,
        LSB_GAIN_X1,
        LSB_GAIN_X9P5,
        LSB_GAIN_X18
    } lsb_gain_t;

    typedef enum {
        LSB_SEQ_IDLE,
        LSB_SEQ_OPENING,
        LSB_SEQ_DEAD
    } lsb_seq_state_t;

    typedef struct packed {
        logic en;
        logic [5:0] idx;
        logic [7:0] data;
    } lsb_wr_t;

    typedef struct packed {
        logic busy;
        logic dead;
    } lsb_seq_stat_t;

    function automatic logic [5:0] lsb_idx_of(input logic [7:0] addr);
        return addr[7:2];
    endfunction

    function automatic logic lsb_is_aligned(input logic [7:0] addr);
        return addr[1:0] == 2'h0;
    endfunction

endpackage

// [lsb_apb_port.sv]
`timescale 1ns/1ps
`include "lsb_defs.svh"
module lsb_apb_port import lsb_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] rdata,
    input wire logic hit,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output lsb_wr_t wr
);

    logic access;
    logic done;

    // One wait state so read data can be registered
    assign access = psel && penable;
    assign done = access && pready;

    always_comb begin
        wr.en = done && pwrite && hit;
        wr.idx = lsb_idx_of(paddr);
        wr.data = pwdata[7:0];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= (hit && !pwrite) ? rdata : 32'h00000000;
            pslverr <= !hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule

// [lsb_strobe_seq.sv]
`timescale 1ns/1ps
`include "lsb_defs.svh"
module lsb_strobe_seq import lsb_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] colour_select_in,
    input wire logic [7:0] dead_time_code,
    output logic [2:0] switch_close,
    output lsb_seq_stat_t stat
);

    lsb_seq_state_t state_reg;
    logic [1:0] sel_prev_reg;
    logic [1:0] target_reg;
    logic [4:0] open_cnt_reg;
    logic [15:0] acc_ns_reg;
    logic [15:0] dead_ns;
    logic change;

    function automatic logic [2:0] close_of(input logic [1:0] sel);
        case (sel)
            2'h1: return 3'h1;
            2'h2: return 3'h2;
            2'h3: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction

    assign change = colour_select_in != sel_prev_reg;
    assign dead_ns = 16'(`LSB_DEAD_BASE_NS) + 16'(`LSB_DEAD_STEP_NS) * {8'h00, dead_time_code};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_prev_reg <= 2'h0;
        end else begin
            sel_prev_reg <= colour_select_in;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= LSB_SEQ_IDLE;
            target_reg <= 2'h0;
            open_cnt_reg <= 5'h00;
            acc_ns_reg <= 16'h0000;
            switch_close <= 3'h0;
        end else if (change) begin
            // A new select restarts the sequence from the open phase
            state_reg <= LSB_SEQ_OPENING;
            target_reg <= colour_select_in;
            open_cnt_reg <= 5'h01;
        end else begin
            case (state_reg)
                LSB_SEQ_OPENING: begin
                    if (open_cnt_reg == 5'(`LSB_OPEN_CYC)) begin
                        switch_close <= 3'h0;
                        acc_ns_reg <= 16'h0000;
                        state_reg <= LSB_SEQ_DEAD;
                    end else begin
                        open_cnt_reg <= open_cnt_reg + 5'h01;
                    end
                end
                LSB_SEQ_DEAD: begin
                    if (acc_ns_reg + 16'(`LSB_CLK_PERIOD_NS) >= dead_ns) begin
                        switch_close <= close_of(target_reg);
                        state_reg <= LSB_SEQ_IDLE;
                    end else begin
                        acc_ns_reg <= acc_ns_reg + 16'(`LSB_CLK_PERIOD_NS);
                    end
                end
                default: begin
                    state_reg <= LSB_SEQ_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        stat.busy = state_reg != LSB_SEQ_IDLE;
        stat.dead = state_reg == LSB_SEQ_DEAD;
    end

endmodule

// [lsb_regs.sv]
// Functional notes
// - Low current byte, read/write, resets zero
// - Code zero gives no current; linear steps
// - Front end enable bit read-only, resets zero
// - Comparator output released when front end off
// - Trim bypass bit steers calibration trim
// - Two-bit gain field selects amplifier gain
// - Three-bit selector routes one measurement source
// - Dead time code sets switch gap
// - Switches open 333 to 444 ns after change
// - Upper current bits at index 0x07
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "lsb_defs.svh"
module lsb_regs import lsb_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] colour_select_in,
    input wire logic front_end_on_in,
    input wire logic [7:0] fault_flags_in,
    input wire logic comp_in,
    output logic comp_out,
    output logic comp_oe,
    output logic [9:0] third_channel_current_code,
    output logic current_on,
    output logic trim_bypass,
    output logic amp_on,
    output logic [1:0] amp_gain_sel,
    output logic [2:0] meas_source_sel,
    output logic [7:0] meas_route,
    output logic [2:0] switch_close
);

    ////////////////////////////////////////////////////////////////////////////////

    lsb_wr_t wr;
    lsb_seq_stat_t seq_stat;
    logic [5:0] rd_idx;
    logic rd_hit;
    logic [31:0] rdata_next;

    logic [1:0] cur_high_reg;
    logic [7:0] cur_low_reg;
    logic trim_reg;
    logic [1:0] gain_reg;
    logic [2:0] sel_reg;
    logic [7:0] dead_time_reg;
    logic front_end_on_reg;
    logic [7:0] fault_reg;
    logic [9:0] code_next;
    lsb_gain_t gain_mode;
    logic wr_cur_high;
    logic wr_cur_low;
    logic wr_fe_ctrl;
    logic wr_dead_time;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic idx_mapped(input logic [5:0] idx);
        logic ok;
        ok = 1'b0;
        if (idx == `LSB_IDX_CUR_HIGH) begin
            ok = 1'b1;
        end else if (idx == `LSB_IDX_CUR_LOW) begin
            ok = 1'b1;
        end else if (idx == `LSB_IDX_FE_CTRL) begin
            ok = 1'b1;
        end else if (idx == `LSB_IDX_DEAD_TIME) begin
            ok = 1'b1;
        end else if (idx == `LSB_IDX_FAULT) begin
            ok = 1'b1;
        end else if (idx == `LSB_IDX_SEQ_STAT) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    function automatic logic wr_to(input lsb_wr_t w, input logic [5:0] idx);
        return w.en && (w.idx == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    assign rd_idx = lsb_idx_of(paddr);
    assign rd_hit = lsb_is_aligned(paddr) && idx_mapped(rd_idx);

    // One write strobe per writable register
    assign wr_cur_high = wr_to(wr, `LSB_IDX_CUR_HIGH);
    assign wr_cur_low = wr_to(wr, `LSB_IDX_CUR_LOW);
    assign wr_fe_ctrl = wr_to(wr, `LSB_IDX_FE_CTRL);
    assign wr_dead_time = wr_to(wr, `LSB_IDX_DEAD_TIME);

    lsb_apb_port u_port (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .rdata(rdata_next),
        .hit(rd_hit),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wr(wr)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_high_reg <= `LSB_RST_CUR_HIGH;
        end else if (wr_cur_high) begin
            cur_high_reg <= wr.data[`LSB_CUR_HIGH_HI:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_low_reg <= `LSB_RST_CUR_LOW;
        end else if (wr_cur_low) begin
            cur_low_reg <= wr.data;
        end
    end

    // Front end control; the enable bit is not writable
    // Trim bypass write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trim_reg <= `LSB_RST_TRIM;
        end else if (wr_fe_ctrl) begin
            trim_reg <= wr.data[`LSB_TRIM_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gain_reg <= `LSB_RST_GAIN;
        end else if (wr_fe_ctrl) begin
            gain_reg <= wr.data[`LSB_GAIN_HI:`LSB_GAIN_LO];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_reg <= `LSB_RST_SEL;
        end else if (wr_fe_ctrl) begin
            sel_reg <= wr.data[`LSB_SEL_HI:`LSB_SEL_LO];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dead_time_reg <= `LSB_RST_DEAD_TIME;
        end else if (wr_dead_time) begin
            dead_time_reg <= wr.data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            front_end_on_reg <= 1'b0;
        end else begin
            front_end_on_reg <= front_end_on_in;
        end
    end

    // Fault flags are live levels; sampled every clock into fault_reg to keep reads stable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fault_reg <= `LSB_RST_FAULT;
        end else begin
            fault_reg <= fault_flags_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        rdata_next = 32'h00000000;
        if (rd_idx == `LSB_IDX_CUR_HIGH) begin
            rdata_next[`LSB_CUR_HIGH_HI:0] = cur_high_reg;
        end else if (rd_idx == `LSB_IDX_CUR_LOW) begin
            rdata_next[7:0] = cur_low_reg;
        end else if (rd_idx == `LSB_IDX_FE_CTRL) begin
            rdata_next[`LSB_FE_ON_BIT] = front_end_on_reg;
            rdata_next[`LSB_TRIM_BIT] = trim_reg;
            rdata_next[`LSB_GAIN_HI:`LSB_GAIN_LO] = gain_reg;
            rdata_next[`LSB_SEL_HI:`LSB_SEL_LO] = sel_reg;
        end else if (rd_idx == `LSB_IDX_DEAD_TIME) begin
            rdata_next[7:0] = dead_time_reg;
        end else if (rd_idx == `LSB_IDX_FAULT) begin
            rdata_next[7:0] = fault_reg;
        end else if (rd_idx == `LSB_IDX_SEQ_STAT) begin
            rdata_next[`LSB_STAT_BUSY_BIT] = seq_stat.busy;
            rdata_next[`LSB_STAT_DEAD_BIT] = seq_stat.dead;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign code_next = {cur_high_reg, cur_low_reg};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            third_channel_current_code <= 10'h000;
        end else begin
            third_channel_current_code <= code_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            current_on <= 1'b0;
        end else begin
            current_on <= code_next != 10'h000;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            comp_out <= 1'b0;
        end else begin
            comp_out <= front_end_on_reg && comp_in;
        end
    end

    // Pad goes high-Z whenever the enable is low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            comp_oe <= 1'b0;
        end else begin
            comp_oe <= front_end_on_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign gain_mode = lsb_gain_t'(gain_reg);

    // Analog controls registered so they never glitch during a bus write
    // Trim bypass drive
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trim_bypass <= 1'b0;
        end else begin
            trim_bypass <= trim_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            amp_on <= 1'b0;
        end else begin
            amp_on <= gain_mode != LSB_GAIN_OFF;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            amp_gain_sel <= 2'h0;
        end else begin
            amp_gain_sel <= gain_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meas_source_sel <= 3'h0;
        end else begin
            meas_source_sel <= sel_reg;
        end
    end

    // One flop per route bit, so only the old and new source toggle
    for (genvar s = 0; s < 8; s++) begin : g_route
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                meas_route[s] <= 1'b0;
            end else begin
                meas_route[s] <= sel_reg == 3'(s);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    lsb_strobe_seq u_seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .colour_select_in(colour_select_in),
        .dead_time_code(dead_time_reg),
        .switch_close(switch_close),
        .stat(seq_stat)
    );

endmodule

// [lsb_regs_sva.sv]
`timescale 1ns/1ps
`include "lsb_defs.svh"
module lsb_regs_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] colour_select_in,
    input wire logic front_end_on_in,
    input wire logic comp_oe,
    input wire logic [9:0] third_channel_current_code,
    input wire logic current_on,
    input wire logic trim_bypass,
    input wire logic amp_on,
    input wire logic [1:0] amp_gain_sel,
    input wire logic [2:0] meas_source_sel,
    input wire logic [7:0] meas_route,
    input wire logic [2:0] switch_close
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Completed write without error
    wire logic acc = psel && penable && pready && pwrite && !pslverr;
    ////////////////////////////////////////////////////////////////////////////////
    low_byte_a: assert property (acc && paddr == {`LSB_IDX_CUR_LOW, 2'h0} |=> ##1
        third_channel_current_code[7:0] == 8'($past(pwdata, 2))) else $error("low byte");
    high_bits_a: assert property (acc && paddr == {`LSB_IDX_CUR_HIGH, 2'h0} |=> ##1
        third_channel_current_code[9:8] == 2'($past(pwdata, 2))) else $error("high bits");
    fe_fields_a: assert property (acc && paddr == {`LSB_IDX_FE_CTRL, 2'h0} |=> ##1
        {trim_bypass, amp_gain_sel, meas_source_sel} == 6'($past(pwdata, 2)))
        else $error("front end fields");
    route_hot_a: assert property ($stable(meas_source_sel)[*2] |->
        meas_route == 8'h01 << meas_source_sel) else $error("route not one-hot");
    amp_off_a: assert property ($stable(amp_gain_sel) ##1 $stable(amp_gain_sel) |->
        amp_on == (amp_gain_sel != 2'h0)) else $error("amp enable");
    zero_current_a: assert property ($stable(third_channel_current_code)[*2] |->
        current_on == (third_channel_current_code != 10'h000)) else $error("current on");
    comp_hiz_a: assert property (!front_end_on_in [*3] |-> !comp_oe)
        else $error("comparator driven");
    open_late_a: assert property ($changed(colour_select_in) |->
        ##[14:18] switch_close == 3'h0) else $error("switches not opened");
    open_early_a: assert property ($changed(colour_select_in) && switch_close != 3'h0
        |-> ##14 switch_close != 3'h0) else $error("switches opened early");
    wait_one_a: assert property (psel && penable && !pready |=> pready)
        else $error("wait state");
    bad_addr_a: assert property (psel && penable && pready && paddr[1:0] != 2'h0
        |-> pslverr) else $error("unaligned accepted");
    cover property (acc);
    cover property ($changed(colour_select_in) && switch_close != 3'h0);
    cover property (pslverr);
endmodule
bind lsb_regs lsb_regs_sva lsb_regs_sva_i (.*);

// [lsb_regs_test.sv]
`timescale 1ns/1ps
`include "lsb_defs.svh"
module lsb_regs_test;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, comp_in = 1'h0, front_end_on_in = 1'h0;
    logic [7:0] paddr = 8'h00, fault_flags_in = 8'h00, d, f, meas_route, v [4];
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [1:0] colour_select_in = 2'h0, amp_gain_sel;
    logic pready, pslverr, comp_out, comp_oe, current_on, trim_bypass, amp_on, ev;
    logic [9:0] third_channel_current_code;
    logic [2:0] meas_source_sel, switch_close;
    logic [5:0] ridx [4] = '{`LSB_IDX_CUR_HIGH, `LSB_IDX_CUR_LOW, `LSB_IDX_FE_CTRL,
        `LSB_IDX_DEAD_TIME};
    // Read-only and reserved bits masked out
    logic [7:0] rmsk [4] = '{8'h03, 8'hFF, 8'h3F, 8'hFF};
    int mismatches = 0, checked = 0;
    lsb_regs lsb_regs_i (.*);
    always #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int dead_cyc(input logic [7:0] c);
        return (`LSB_DEAD_BASE_NS + `LSB_DEAD_STEP_NS * c + 24) / 25;
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // No fixed latency assumed; bounded wait on pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rv = prdata;
        ev = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) mismatches++;
    endtask
    task wr(input logic [5:0] i, input logic [7:0] wd);
        apb(1'h1, {i, 2'h0}, {24'h0, wd});
        chk(ev, 1'h0);
    endtask
    task rd(input logic [5:0] i);
        apb(1'h0, {i, 2'h0}, 32'h0);
        chk(ev, 1'h0);
    endtask
    task sel_run(input logic [1:0] s, input logic [7:0] c);
        int n;
        int o;
        logic [2:0] was, tgt;
        was = switch_close;
        tgt = (s == 2'h0) ? 3'h0 : 3'(3'h1 << (s - 2'h1));
        n = 0;
        o = 0;
        @(posedge ref_clk);
        colour_select_in <= s;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (o == 0 && switch_close === 3'h0) o = n;
        end while (!(o > 0 && switch_close === tgt) && n < 1300);
        if (was != 3'h0) chk(o, 15);
        if (s != 2'h0) chk(n, 15 + dead_cyc(c));
        chk(switch_close, tgt);
    endtask
    task final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rv = $urandom(96836);
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        f = 8'($urandom);
        fault_flags_in <= f;
        foreach (ridx[i]) begin
            rd(ridx[i]);
            chk(rv, 32'h0);
        end
        // Every source code once and every gain code twice, plus all-zero and all-one bytes
        for (int k = 0; k < 8; k++) begin
            foreach (ridx[i]) begin
                d = (k == 0) ? 8'h00 : (k == 7) ? 8'hFF : 8'($urandom);
                if (i == 2) d[4:0] = {k[1:0], k[2:0]};
                wr(ridx[i], d);
                v[i] = d & rmsk[i];
                rd(ridx[i]);
                chk(rv, {24'h0, v[i]});
            end
            repeat (3) @(posedge ref_clk);
            chk(third_channel_current_code, {v[0][1:0], v[1]});
            chk(current_on, {v[0][1:0], v[1]} != 10'h0);
            chk({trim_bypass, amp_gain_sel, meas_source_sel}, v[2][5:0]);
            chk(amp_on, v[2][4:3] != 2'h0);
            chk(meas_route, 8'h01 << v[2][2:0]);
        end
        $display("test registers done");
        wr(`LSB_IDX_FAULT, ~f);
        rd(`LSB_IDX_FAULT);
        chk(rv, {24'h0, f});
        apb(1'h0, {6'h09, 2'h0}, 32'h0);
        chk(ev, 1'h1);
        chk(rv, 32'h0);
        apb(1'h1, {`LSB_IDX_CUR_LOW, 2'h1}, 32'h5A);
        chk(ev, 1'h1);
        rd(`LSB_IDX_CUR_LOW);
        chk(rv, {24'h0, v[1]});
        $display("test refusals done");
        front_end_on_in <= 1'h1;
        comp_in <= 1'h1;
        repeat (4) @(posedge ref_clk);
        chk(comp_oe, 1'h1);
        chk(comp_out, 1'h1);
        rd(`LSB_IDX_FE_CTRL);
        chk(rv[7:6], 2'h1);
        front_end_on_in <= 1'h0;
        repeat (4) @(posedge ref_clk);
        chk(comp_oe, 1'h0);
        rd(`LSB_IDX_FE_CTRL);
        chk(rv[7:6], 2'h0);
        $display("test front end done");
        // Shortest, longest and two random gaps; select 00 last
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            wr(`LSB_IDX_DEAD_TIME, d);
            sel_run(2'(i + 1), d);
        end
        $display("test switching done");
        final_report;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        final_report;
    end
endmodule
